// ===== logic/slsp_link_regs.sv
`timescale 1ns/1ps
module slsp_link_regs #(
  parameter int ADDR_W = slsp_pkg::ADDR_W
) (
  input wire logic aclk, // 50 MHz clock
  input wire logic aresetn, // sync reset, low
  input wire logic ce, // freezes all state when low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic sync_n_pin, // receiver sync request, async
  input wire logic sysref_pin, // sysref, async
  input wire logic pll_lock_pin, // serializer pll lock, async
  input wire logic link_up, // link logic: link operating
  input wire logic realign_pulse, // clock gen: sysref shifted a phase
  output logic link_encoder_enable, // encoder enable
  output logic power_down_channel_a, // channel a and its lanes off
  output logic power_down_channel_b, // channel b and its lanes off
  output logic link_power_down, // whole link subsystem off
  output logic irq // level interrupt
);
  if (ADDR_W < slsp_pkg::ADDR_W)
  begin : g_chk
    $error("ADDR_W too small for the register map");
  end

  function automatic logic [9:0] reg_idx(input logic [ADDR_W-1:0] a);
    reg_idx = a[11:2];
  endfunction

  // pin synchronisers: s1 feeds only s2, change counts when s2 and s3 agree
  logic [2:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, pin_q, pin_d;

  always_comb
  begin
    s1_d = {pll_lock_pin, sysref_pin, sync_n_pin};
    s2_d = s1_q;
    s3_d = s2_q;
    pin_d = pin_q;
    for (int i = 0; i < 3; i++)
    begin
      if (s2_q[i] == s3_q[i])
      begin
        pin_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q <= slsp_pkg::SYNC_RST;
      s2_q <= slsp_pkg::SYNC_RST;
      s3_q <= slsp_pkg::SYNC_RST;
      pin_q <= slsp_pkg::SYNC_RST;
    end
    else if (ce)
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      pin_q <= pin_d;
    end
  end

  // axi handshake state
  logic aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [9:0] widx_q, widx_d;
  logic [31:0] wdat_q, wdat_d;
  logic wstb_q, wstb_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  // register state
  slsp_pkg::slsp_stat_t st_q, st_d;
  logic [1:0] pd_q, pd_d;
  logic en_q, en_d, armed_q, armed_d;
  logic [3:0] ist_q, ist_d, mask_q, mask_d;
  slsp_pkg::slsp_pd_t pdo_q, pdo_d;
  logic irq_q, irq_d;
  logic wr_fire, ar_fire, sysref_evt, phase_established_flag_set, realign_set;
  logic w1c_al, w1c_re, both_pd;
  logic [7:0] stat_word;

  assign sysref_evt = pin_d[1] && !pin_q[1] && !pdo_q.link_off;
  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
  assign ar_fire = s_axi_arvalid && arready_q;
  assign both_pd = pd_q[slsp_pkg::BIT_PD_A] && pd_q[slsp_pkg::BIT_PD_B];
  assign phase_established_flag_set = armed_q && sysref_evt;
  assign realign_set = realign_pulse && !pdo_q.link_off;
  assign w1c_al = wr_fire && wstb_q && widx_q == slsp_pkg::IDX_STATUS &&
    wdat_q[slsp_pkg::BIT_PHASE_ESTABLISHED_FLAG];
  assign w1c_re = wr_fire && wstb_q && widx_q == slsp_pkg::IDX_STATUS &&
    wdat_q[slsp_pkg::BIT_REALIGNED];
  assign stat_word = {1'b0, st_q.link_up, st_q.sync_rel, st_q.realigned,
    st_q.phase_established_flag, st_q.pll_locked, 2'h0};

  always_comb
  begin
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    widx_d = widx_q;
    wdat_d = wdat_q;
    wstb_d = wstb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_awvalid && awready_q)
    begin
      aw_got_d = 1'b1;
      widx_d = reg_idx(s_axi_awaddr);
    end
    if (s_axi_wvalid && wready_q)
    begin
      w_got_d = 1'b1;
      wdat_d = s_axi_wdata;
      wstb_d = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
    if (wr_fire)
    begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      case (widx_q)
        slsp_pkg::IDX_STATUS, slsp_pkg::IDX_PD, slsp_pkg::IDX_IRQ_ST,
        slsp_pkg::IDX_IRQ_MASK, slsp_pkg::IDX_CTRL:
          bresp_d = slsp_pkg::RESP_OKAY;
        default:
          bresp_d = slsp_pkg::RESP_SLVERR;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
    if (ar_fire)
    begin
      rvalid_d = 1'b1;
      rresp_d = slsp_pkg::RESP_OKAY;
      case (reg_idx(s_axi_araddr))
        slsp_pkg::IDX_STATUS: rdata_d = {24'h000000, stat_word};
        slsp_pkg::IDX_PD: rdata_d = {30'h00000000, pd_q};
        slsp_pkg::IDX_IRQ_ST: rdata_d = {28'h0000000, ist_q};
        slsp_pkg::IDX_IRQ_MASK: rdata_d = {28'h0000000, mask_q};
        slsp_pkg::IDX_CTRL: rdata_d = {31'h00000000, en_q};
        default:
        begin
          rdata_d = slsp_pkg::DATA_RST;
          rresp_d = slsp_pkg::RESP_SLVERR;
        end
      endcase
    end
    awready_d = !aw_got_d;
    wready_d = !w_got_d;
    // one read in flight; next address taken after the data is accepted
    arready_d = !rvalid_d;
  end

  always_comb
  begin
    st_d = st_q;
    pd_d = pd_q;
    en_d = en_q;
    mask_d = mask_q;
    armed_d = armed_q;
    st_d.link_up = link_up;
    st_d.sync_rel = pin_q[0];
    st_d.pll_locked = pin_q[2];
    if (wr_fire && wstb_q)
    begin
      case (widx_q)
        slsp_pkg::IDX_PD: pd_d = wdat_q[1:0];
        slsp_pkg::IDX_IRQ_MASK: mask_d = wdat_q[3:0];
        slsp_pkg::IDX_CTRL: en_d = wdat_q[0];
        default: pd_d = pd_q;
      endcase
    end
    // clear first, set after: set wins within a cycle
    if (w1c_al)
    begin
      st_d.phase_established_flag = 1'b0;
    end
    if (w1c_re)
    begin
      st_d.realigned = 1'b0;
    end
    if (phase_established_flag_set)
    begin
      st_d.phase_established_flag = 1'b1;
      armed_d = 1'b0;
    end
    if (realign_set)
    begin
      st_d.realigned = 1'b1;
    end
    // arm on the rising edge of encoder enable
    if (en_d && !en_q)
    begin
      armed_d = 1'b1;
    end
    if (!en_d)
    begin
      armed_d = 1'b0;
    end
    // no interlock against pd writes with encoder on; software's duty
    pdo_d.ch_a = pd_d[slsp_pkg::BIT_PD_A];
    pdo_d.ch_b = pd_d[slsp_pkg::BIT_PD_B];
    pdo_d.link_off = both_pd;
    ist_d = ist_q;
    if (wr_fire && wstb_q && widx_q == slsp_pkg::IDX_IRQ_ST)
    begin
      ist_d = ist_q & ~wdat_q[3:0];
    end
    if (phase_established_flag_set)
    begin
      ist_d[slsp_pkg::IRQ_PHASE_ESTABLISHED_FLAG] = 1'b1;
    end
    if (realign_set)
    begin
      ist_d[slsp_pkg::IRQ_REALIGNED] = 1'b1;
    end
    if (st_q.link_up && !link_up)
    begin
      ist_d[slsp_pkg::IRQ_LINK_DOWN] = 1'b1;
    end
    if (pin_q[2] && !pin_d[2])
    begin
      ist_d[slsp_pkg::IRQ_PLL_LOST] = 1'b1;
    end
    irq_d = |(ist_q & mask_q);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      widx_q <= 10'h000;
      wdat_q <= slsp_pkg::DATA_RST;
      wstb_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= slsp_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= slsp_pkg::RESP_OKAY;
      rdata_q <= slsp_pkg::DATA_RST;
      st_q <= slsp_pkg::STAT_RST;
      pd_q <= slsp_pkg::PD_RST;
      en_q <= 1'b0;
      armed_q <= 1'b0;
      ist_q <= slsp_pkg::IRQ_RST;
      mask_q <= slsp_pkg::IRQ_RST;
      pdo_q <= slsp_pkg::PDO_RST;
      irq_q <= 1'b0;
    end
    else if (ce)
    begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      widx_q <= widx_d;
      wdat_q <= wdat_d;
      wstb_q <= wstb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      st_q <= st_d;
      pd_q <= pd_d;
      en_q <= en_d;
      armed_q <= armed_d;
      ist_q <= ist_d;
      mask_q <= mask_d;
      pdo_q <= pdo_d;
      irq_q <= irq_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign link_encoder_enable = en_q;
  assign power_down_channel_a = pdo_q.ch_a;
  assign power_down_channel_b = pdo_q.ch_b;
  assign link_power_down = pdo_q.link_off;
  assign irq = irq_q;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_arm_then_ref;
    ce && armed_q && sysref_evt;
  endsequence

  sequence s_phase_established_flag_cleared;
    !st_q.phase_established_flag && !armed_q;
  endsequence

  a_first_sysref: assert property (s_arm_then_ref |=> st_q.phase_established_flag)
    else $error("first sysref did not set phase_established_flag");
  a_arm_once: assert property (s_arm_then_ref ##1 (ce && w1c_al && !sysref_evt)
    |=> s_phase_established_flag_cleared)
    else $error("phase_established_flag set again without re-arm");
  a_realign_hold: assert property (ce && st_q.realigned && !w1c_re |=>
    st_q.realigned)
    else $error("realigned dropped without a clear");
  a_set_wins: assert property (ce && w1c_re && realign_set |=>
    st_q.realigned)
    else $error("clear beat set on realigned");
  a_sync_live: assert property (ce && s2_q[0] == s3_q[0] ##1 ce |=>
    st_q.sync_rel == $past(s3_q[0], 2))
    else $error("sync status not following pin");
  a_status_read: assert property (ar_fire && ce &&
    reg_idx(s_axi_araddr) == slsp_pkg::IDX_STATUS |=> s_axi_rvalid &&
    s_axi_rdata[6] == $past(st_q.link_up) &&
    s_axi_rdata[2] == $past(st_q.pll_locked))
    else $error("status read returned wrong bits");
  a_pd_reset: assert property (disable iff (1'b0) !aresetn |=>
    pd_q == slsp_pkg::PD_RST && !link_power_down)
    else $error("power-down not zero after reset");
  // pd_q and its output copy load at the same edge, so compare them unshifted
  a_pd_follow: assert property (
    power_down_channel_a == pd_q[slsp_pkg::BIT_PD_A] &&
    power_down_channel_b == pd_q[slsp_pkg::BIT_PD_B])
    else $error("channel power-down outputs lag");
  a_link_off: assert property (
    ce |=> link_power_down == $past(both_pd))
    else $error("link not powered down with both channels");
  a_irq_level: assert property (ce |=> irq == $past(|(ist_q & mask_q)))
    else $error("irq not equal to masked status");
endmodule

// ===== logic/slsp_pkg.sv
package slsp_pkg;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  // printed offsets are register indices; byte address is four times these
  localparam logic [9:0] IDX_STATUS = 10'h208;
  localparam logic [9:0] IDX_PD = 10'h209;
  localparam logic [9:0] IDX_IRQ_ST = 10'h210;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h211;
  localparam logic [9:0] IDX_CTRL = 10'h212;
  // link_status fields
  localparam int BIT_LINK_UP = 6;
  localparam int BIT_SYNC = 5;
  localparam int BIT_REALIGNED = 4;
  localparam int BIT_PHASE_ESTABLISHED_FLAG = 3;
  localparam int BIT_PLL = 2;
  // channel_power_down fields
  localparam int BIT_PD_B = 1;
  localparam int BIT_PD_A = 0;
  // interrupt status / mask fields
  localparam int IRQ_W = 4;
  localparam int IRQ_PHASE_ESTABLISHED_FLAG = 0;
  localparam int IRQ_REALIGNED = 1;
  localparam int IRQ_LINK_DOWN = 2;
  localparam int IRQ_PLL_LOST = 3;
  // reset values and bus response codes
  localparam logic [1:0] PD_RST = 2'h0;
  localparam logic [3:0] IRQ_RST = 4'h0;
  localparam logic [2:0] SYNC_RST = 3'h0;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // number of stages in each pin synchroniser
  localparam int SYNC_STAGES = 3;

  typedef struct packed {
    logic link_up;
    logic sync_rel;
    logic realigned;
    logic phase_established_flag;
    logic pll_locked;
  } slsp_stat_t;

  localparam slsp_stat_t STAT_RST = '{default: 1'b0};

  typedef struct packed {
    logic link_off;
    logic ch_b;
    logic ch_a;
  } slsp_pd_t;

  localparam slsp_pd_t PDO_RST = '{default: 1'b0};
endpackage

// ===== test/slsp_rx_model.sv
`timescale 1ns/1ps
module slsp_rx_model (
  input wire logic aclk, // clock
  input wire logic want_sync_rel, // release the sync request
  input wire logic want_lock, // serializer pll lock level
  input wire logic want_up, // link operating level
  input wire logic fire_sysref, // start one sysref pulse
  input wire logic fire_realign, // one realign strobe
  output logic sync_n_pin, // low = receiver requests sync
  output logic sysref_pin, // sysref to the device
  output logic pll_lock_pin, // pll lock to the device
  output logic link_up, // link logic level
  output logic realign_pulse // phase shifted strobe
);
  int cnt;
  initial
  begin
    cnt = 0;
    sync_n_pin = 1'b0;
    sysref_pin = 1'b0;
    pll_lock_pin = 1'b0;
    link_up = 1'b0;
    realign_pulse = 1'b0;
  end
  // sysref held several cycles so the pin synchroniser surely sees it
  always @(posedge aclk)
  begin
    sync_n_pin <= want_sync_rel;
    pll_lock_pin <= want_lock;
    link_up <= want_up;
    realign_pulse <= fire_realign;
    if (fire_sysref)
      cnt <= 6;
    else if (cnt > 0)
      cnt <= cnt - 1;
    sysref_pin <= fire_sysref || cnt > 1;
  end
endmodule

// ===== test/serial_link_status_and_powerdown_tb.sv
`timescale 1ns/1ps
module serial_link_status_and_powerdown_tb;
  typedef struct packed {
    logic [9:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [1:0] resp;
  } slsp_row_t;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, link_encoder_enable, link_power_down;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic sync_n_pin, sysref_pin, pll_lock_pin, link_up, realign_pulse;
  logic power_down_channel_a, power_down_channel_b;
  logic want_sync_rel = 1'b0, want_lock = 1'b0, want_up = 1'b0;
  logic fire_sysref = 1'b0, fire_realign = 1'b0;
  int n_fail = 0, checks = 0;
  slsp_row_t rows [6] = '{
    '{slsp_pkg::IDX_PD, 8'hFF, 8'h03, slsp_pkg::RESP_OKAY},
    '{slsp_pkg::IDX_PD, 8'h02, 8'h02, slsp_pkg::RESP_OKAY},
    '{slsp_pkg::IDX_STATUS, 8'hFF, 8'h00, slsp_pkg::RESP_OKAY},
    '{slsp_pkg::IDX_IRQ_MASK, 8'h01, 8'h01, slsp_pkg::RESP_OKAY},
    '{10'h3FF, 8'h5A, 8'h00, slsp_pkg::RESP_SLVERR},
    '{slsp_pkg::IDX_PD, 8'h01, 8'h01, slsp_pkg::RESP_OKAY}};

  slsp_link_regs dut_u (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sync_n_pin, .sysref_pin, .pll_lock_pin, .link_up, .realign_pulse,
    .link_encoder_enable, .power_down_channel_a, .power_down_channel_b,
    .link_power_down, .irq);
  slsp_rx_model rx_u (.aclk, .want_sync_rel, .want_lock, .want_up,
    .fire_sysref, .fire_realign, .sync_n_pin, .sysref_pin, .pll_lock_pin,
    .link_up, .realign_pulse);

  initial
  begin
    forever #10 aclk = ~aclk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string m);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic timeout();
    n_fail++;
    $display("wrong value at %0t: bus wait ran out", $time);
    print_verdict();
  endtask

  task automatic axi_wr(input logic [9:0] idx, input logic [7:0] d,
    output logic [1:0] r);
    int n;
    bit done;
    n = 0;
    done = 0;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done && n < 100)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        done = 1;
      end
      n++;
    end
    s_axi_bready <= 1'b0;
    if (!done)
      timeout();
  endtask

  task automatic axi_rd(input logic [9:0] idx, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    bit done;
    n = 0;
    done = 0;
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done && n < 100)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        done = 1;
      end
      n++;
    end
    s_axi_rready <= 1'b0;
    if (!done)
      timeout();
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    axi_wr(idx, d, rsp);
    chk({30'h0, rsp}, {30'h0, slsp_pkg::RESP_OKAY}, "write resp");
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] e,
    input string m);
    axi_rd(idx, rd, rsp);
    chk(rd, {24'h00_0000, e}, m);
  endtask

  task automatic strobe(input bit is_sysref);
    if (is_sysref)
      fire_sysref <= 1'b1;
    else
      fire_realign <= 1'b1;
    @(posedge aclk);
    fire_sysref <= 1'b0;
    fire_realign <= 1'b0;
    repeat (15) @(posedge aclk);
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  initial
  begin
    do_reset();
    for (int i = 0; i < 6; i++)
    begin
      axi_wr(rows[i].idx, rows[i].wd, rsp);
      chk({30'h0, rsp}, {30'h0, rows[i].resp}, "row wr resp");
      axi_rd(rows[i].idx, rd, rsp);
      chk({30'h0, rsp}, {30'h0, rows[i].resp}, "row rd resp");
      chk(rd, {24'h00_0000, rows[i].rd}, "row data");
    end
    $display("table rows done");
    do_reset();
    rd_chk(slsp_pkg::IDX_PD, 8'h00, "pd after reset");
    chk({31'h0, power_down_channel_a}, 32'h0, "pd a reset");
    $display("reset test done");
    want_sync_rel <= 1'b1;
    want_lock <= 1'b1;
    want_up <= 1'b1;
    repeat (10) @(posedge aclk);
    rd_chk(slsp_pkg::IDX_STATUS, 8'h64, "live bits");
    want_sync_rel <= 1'b0;
    want_lock <= 1'b0;
    want_up <= 1'b0;
    repeat (10) @(posedge aclk);
    rd_chk(slsp_pkg::IDX_STATUS, 8'h00, "live bits low");
    $display("live status test done");
    wr(slsp_pkg::IDX_IRQ_ST, 8'h0F);
    wr(slsp_pkg::IDX_IRQ_MASK, 8'h01);
    wr(slsp_pkg::IDX_CTRL, 8'h01);
    chk({31'h0, irq}, 32'h0, "irq idle");
    strobe(1);
    rd_chk(slsp_pkg::IDX_STATUS, 8'h08, "phase_established_flag set");
    chk({31'h0, irq}, 32'h1, "irq raised");
    wr(slsp_pkg::IDX_STATUS, 8'h00);
    rd_chk(slsp_pkg::IDX_STATUS, 8'h08, "zero write kept");
    wr(slsp_pkg::IDX_STATUS, 8'h08);
    rd_chk(slsp_pkg::IDX_STATUS, 8'h00, "phase_established_flag cleared");
    strobe(1);
    rd_chk(slsp_pkg::IDX_STATUS, 8'h00, "only first sysref");
    wr(slsp_pkg::IDX_IRQ_ST, 8'h0F);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    strobe(0);
    rd_chk(slsp_pkg::IDX_STATUS, 8'h10, "realigned set");
    wr(slsp_pkg::IDX_STATUS, 8'h10);
    rd_chk(slsp_pkg::IDX_STATUS, 8'h00, "realigned cleared");
    ce <= 1'b0;
    strobe(0);
    ce <= 1'b1;
    rd_chk(slsp_pkg::IDX_STATUS, 8'h00, "frozen by ce");
    $display("sticky flag test done");
    wr(slsp_pkg::IDX_CTRL, 8'h00);
    wr(slsp_pkg::IDX_PD, 8'h01);
    chk({30'h0, power_down_channel_b, power_down_channel_a}, 32'h1,
      "pd a only");
    wr(slsp_pkg::IDX_PD, 8'h02);
    chk({30'h0, power_down_channel_b, power_down_channel_a}, 32'h2,
      "pd b only");
    chk({31'h0, link_power_down}, 32'h0, "link kept");
    wr(slsp_pkg::IDX_PD, 8'h03);
    repeat (2) @(posedge aclk);
    chk({31'h0, link_power_down}, 32'h1, "link off");
    $display("power down test done");
    print_verdict();
  end
endmodule
